// >>> hsc_consts.svh
// Purpose: constants of the serial control port
// Assumes: included by hsc_ctrl.sv
// Notes: definitions only
`ifndef HSC_CONSTS_SVH
`define HSC_CONSTS_SVH
`define HSC_ADDR_WR 8'hE8
`define HSC_ADDR_EVT 8'hEA
`define HSC_ADDR_RATE 8'hEB
`define HSC_ADDR_CHAN 8'hEC
`define HSC_ADDR_BURST 8'hED
`define HSC_CMD_SYS1 4'h0
`define HSC_CMD_CLK 4'h2
`define HSC_CMD_INTSEL 4'h8
`define HSC_READBACK_DRIVE_ALLOW_BIT 1
`define HSC_AMP_HI 7
`define HSC_AMP_LO 6
`define HSC_AMP_AUTO 2'h2
`define HSC_AMP_STOP 2'h3
`define HSC_AMP_RST 2'h0
`define HSC_EN_RST 8'h00
`define HSC_WR_BITS 5'h10
`define HSC_SRC_FAULT 0
`define HSC_SRC_NONPCM 4
`endif

// >>> hsc_ctrl.sv
// Purpose: serial control port with interrupt output
// Assumes: pins are asynchronous to i_sys_clk; CL much slower
// Notes: readback changes on falling shift-clock edges
`timescale 1ns/10ps
`default_nettype none
`include "hsc_consts.svh"
module hsc_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_shift_timing_line,
  input wire logic i_frame_strobe,
  input wire logic i_host_serial_in,
  input wire logic i_receive_fault_flag,
  input wire logic i_nonpcm_flag,
  input wire logic i_chip_id_low_bit,
  input wire logic i_chip_id_high_bit,
  input wire logic i_pll_locked,
  input wire hsc_pkg::hsc_evt_t i_evt,
  input wire hsc_pkg::hsc_rd_t i_rd,
  output logic o_host_serial_out,
  output logic o_host_serial_out_oe_n,
  output logic o_int_n,
  output var hsc_pkg::hsc_cmd_t o_cmd
);
  // Reset release through two flops
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Pin synchronisers: CL, CE, DI, fault, non-PCM
  localparam int NP = 5;
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, prv_q;
  assign pin_raw = {i_nonpcm_flag, i_receive_fault_flag, i_host_serial_in,
                    i_frame_strobe, i_shift_timing_line};
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_sync
      // Level accepted once second and third stages agree
      always_comb begin
        lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
      end
      always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          lvl_q[g] <= 1'b0;
          prv_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          lvl_q[g] <= lvl_d[g];
          prv_q[g] <= lvl_q[g];
        end
      end
    end
  endgenerate
  // Edge strobes of filtered pins
  logic cl_rise, cl_fall, ce_rise, ce_fall, ce, di, fault, nonpcm;
  assign cl_rise = lvl_q[0] & ~prv_q[0];
  assign cl_fall = ~lvl_q[0] & prv_q[0];
  assign ce = lvl_q[1];
  assign ce_rise = lvl_q[1] & ~prv_q[1];
  assign ce_fall = ~lvl_q[1] & prv_q[1];
  assign di = lvl_q[2];
  assign fault = lvl_q[3];
  assign nonpcm = lvl_q[4];

  // Frame sequencer state and settings
  hsc_pkg::hsc_state_t st_q, st_d;
  logic [7:0] addr_q, addr_d;   // Bus address shifter
  logic [15:0] wr_q, wr_d;      // Write shifter
  logic [4:0] cnt_q, cnt_d;     // Write bit count, saturating
  logic [15:0] rd_q, rd_d;      // Readback shifter
  logic [7:0] en_q, en_d;       // Source enables
  logic allow_q, allow_d;       // Readback drive allowed
  logic [1:0] amp_q, amp_d;     // Oscillator amplifier mode
  logic [1:0] chip_q, chip_d;   // Strapped chip id
  logic strap_q, strap_d;       // Strap captured
  hsc_pkg::hsc_cmd_t cmd_d;
  logic clr;                    // Status address set
  logic [7:0] pend_q;

  // Decoding of the readback source for an address
  function automatic logic [15:0] rd_sel(input logic [7:0] a, input hsc_pkg::hsc_rd_t r,
                                         input logic [7:0] p, input logic f, input logic n);
    logic [7:0] s;
    s = p;
    s[`HSC_SRC_FAULT] = f;
    s[`HSC_SRC_NONPCM] = n;
    if (a == `HSC_ADDR_EVT) begin
      rd_sel = {s, r.detect};
    end else if (a == `HSC_ADDR_RATE) begin
      rd_sel = r.rate;
    end else if (a == `HSC_ADDR_CHAN) begin
      rd_sel = r.chan;
    end else begin
      rd_sel = r.burst;
    end
  endfunction

  // Next values of the frame sequencer
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wr_d = wr_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    en_d = en_q;
    allow_d = allow_q;
    amp_d = amp_q;
    chip_d = chip_q;
    strap_d = 1'b1;
    cmd_d = '0;
    clr = 1'b0;
    // Straps caught once after reset release
    if (!strap_q) begin
      chip_d = {i_chip_id_high_bit, i_chip_id_low_bit};
    end
    case (st_q)
      hsc_pkg::ST_ADDR: begin
        // Address bits LSB first while strobe low
        if (cl_rise && !ce) begin
          addr_d = {di, addr_q[7:1]};
        end
        if (ce_rise) begin
          if (addr_q == `HSC_ADDR_WR) begin
            st_d = hsc_pkg::ST_WR;
            cnt_d = 5'h00;
          end else if (addr_q >= `HSC_ADDR_EVT && addr_q <= `HSC_ADDR_BURST) begin
            st_d = hsc_pkg::ST_RD;
            rd_d = rd_sel(addr_q, i_rd, pend_q, fault, nonpcm);
            clr = (addr_q == `HSC_ADDR_EVT);
          end else begin
            st_d = hsc_pkg::ST_IGN;
          end
        end
      end
      hsc_pkg::ST_WR: begin
        // Data bits LSB first on rising clock
        if (cl_rise && cnt_q != `HSC_WR_BITS) begin
          wr_d = {di, wr_q[15:1]};
          cnt_d = cnt_q + 5'h01;
        end
        if (ce_fall) begin
          st_d = hsc_pkg::ST_ADDR;
          // Commit only full frames for this chip
          if (cnt_q == `HSC_WR_BITS && wr_q[1:0] == chip_q && wr_q[3:2] == 2'h0) begin
            cmd_d = {1'b1, wr_q[7:4], wr_q[15:8]};
            if (wr_q[7:4] == `HSC_CMD_SYS1) begin
              allow_d = ~wr_q[8 + `HSC_READBACK_DRIVE_ALLOW_BIT];
            end else if (wr_q[7:4] == `HSC_CMD_CLK) begin
              amp_d = wr_q[8 + `HSC_AMP_HI : 8 + `HSC_AMP_LO];
            end else if (wr_q[7:4] == `HSC_CMD_INTSEL) begin
              en_d = wr_q[15:8];
            end
          end
        end
      end
      hsc_pkg::ST_RD: begin
        // Next bit presented after each falling clock
        if (cl_fall) begin
          rd_d = {1'b0, rd_q[15:1]};
        end
        if (ce_fall) begin
          st_d = hsc_pkg::ST_ADDR;
        end
      end
      default: begin
        // Unknown address: wait for strobe to fall
        if (ce_fall) begin
          st_d = hsc_pkg::ST_ADDR;
        end
      end
    endcase
  end

  // Frame sequencer registers
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= hsc_pkg::ST_ADDR;
      addr_q <= 8'h00;
      wr_q <= 16'h0000;
      cnt_q <= 5'h00;
      rd_q <= 16'h0000;
      en_q <= `HSC_EN_RST;
      allow_q <= 1'b1;
      amp_q <= `HSC_AMP_RST;
      chip_q <= 2'h0;
      strap_q <= 1'b0;
      o_cmd <= '0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      en_q <= en_d;
      allow_q <= allow_d;
      amp_q <= amp_d;
      chip_q <= chip_d;
      strap_q <= strap_d;
      o_cmd <= cmd_d;
    end
  end

  // Three-state readback, floating outside read frames
  assign o_host_serial_out = rd_q[0];
  assign o_host_serial_out_oe_n = ~((st_q == hsc_pkg::ST_RD) & allow_q);

  // Event detection and sticky flags
  logic amp_run;
  logic fault_prv_q, nonpcm_prv_q, emph_prv_q;
  logic [7:0] fire, pend_d;
  always_comb begin
    amp_run = (amp_q != `HSC_AMP_STOP) && !(amp_q == `HSC_AMP_AUTO && i_pll_locked);
    fire[0] = fault != fault_prv_q;
    fire[1] = i_evt.input_activity_chg & amp_run;
    fire[2] = i_evt.rate_result_chg & amp_run;
    fire[3] = i_evt.chan_stat_updated;
    fire[4] = nonpcm != nonpcm_prv_q;
    fire[5] = i_evt.burst_info_updated;
    fire[6] = i_evt.gpio_in_chg;
    fire[7] = i_evt.preemph_info != emph_prv_q;
    fire = fire & en_q;
    // New event wins over a clear in the same cycle
    pend_d = (pend_q & {8{~clr}}) | fire;
  end
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 8'h00;
      fault_prv_q <= 1'b0;
      nonpcm_prv_q <= 1'b0;
      emph_prv_q <= 1'b0;
      o_int_n <= 1'b1;
    end else begin
      pend_q <= pend_d;
      fault_prv_q <= fault;
      nonpcm_prv_q <= nonpcm;
      emph_prv_q <= i_evt.preemph_info;
      o_int_n <= ~|pend_d;
    end
  end

  // Checks of the port behaviour
  property p_int_set;
    @(posedge i_sys_clk) disable iff (!rst_n) |fire |=> !o_int_n;
  endproperty
  a_int_set: assert property (p_int_set) else $error("interrupt missed event");
  property p_int_quiet;
    @(posedge i_sys_clk) disable iff (!rst_n) (o_int_n && !(|fire)) |=> o_int_n;
  endproperty
  a_int_quiet: assert property (p_int_quiet) else $error("interrupt without event");
  property p_int_clr;
    @(posedge i_sys_clk) disable iff (!rst_n) (clr && !(|fire)) |=> o_int_n;
  endproperty
  a_int_clr: assert property (p_int_clr) else $error("status read did not clear");
  property p_no_clr;
    @(posedge i_sys_clk) disable iff (!rst_n) (!o_int_n && !clr) |=> !o_int_n;
  endproperty
  a_no_clr: assert property (p_no_clr) else $error("interrupt cleared wrongly");
  property p_float;
    @(posedge i_sys_clk) disable iff (!rst_n) (!ce && !prv_q[1]) |-> o_host_serial_out_oe_n;
  endproperty
  a_float: assert property (p_float) else $error("readback driven with strobe low");
  property p_readback_drive_allow;
    @(posedge i_sys_clk) disable iff (!rst_n) !allow_q |-> o_host_serial_out_oe_n;
  endproperty
  a_readback_drive_allow: assert property (p_readback_drive_allow) else $error("readback driven while disabled");
  property p_live;
    @(posedge i_sys_clk) disable iff (!rst_n) (clr && !cl_fall) |=> rd_q[8] == $past(fault);
  endproperty
  a_live: assert property (p_live) else $error("fault bit not live");
  property p_amp;
    @(posedge i_sys_clk) disable iff (!rst_n) (amp_q == `HSC_AMP_STOP) |-> !fire[1] && !fire[2];
  endproperty
  a_amp: assert property (p_amp) else $error("source fired with amplifier stopped");
  // Automatic mode parks the amplifier while locked, so sources 2 and 3 stay quiet
  property p_amp_auto;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (amp_q == `HSC_AMP_AUTO && i_pll_locked) |-> !fire[1] && !fire[2];
  endproperty
  a_amp_auto: assert property (p_amp_auto) else $error("source fired with amplifier parked on lock");
  property p_commit;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (o_cmd.valid && o_cmd.cmd == `HSC_CMD_INTSEL) |-> en_q == o_cmd.data ##1 !o_cmd.valid;
  endproperty
  a_commit: assert property (p_commit) else $error("enable write not committed");
  c_write: cover property (@(posedge i_sys_clk) disable iff (!rst_n) o_cmd.valid);
  c_read: cover property (@(posedge i_sys_clk) disable iff (!rst_n) !o_host_serial_out_oe_n ##1 cl_fall);
  c_int: cover property (@(posedge i_sys_clk) disable iff (!rst_n) !o_int_n ##[1:300] o_int_n);
  // Rate event arriving while the amplifier is not running
  c_amp_gate: cover property (@(posedge i_sys_clk) disable iff (!rst_n) !amp_run && i_evt.rate_result_chg);
endmodule
`default_nettype wire

// >>> hsc_host_model.sv
// Purpose: host side of the serial control port
// Assumes: shift clock half period is 4 system clocks (160 ns), except the low phase of reads, 8 clocks (320 ns)
// Notes: pins change on falling system clock edges only
`timescale 1ns/10ps
`default_nettype none
module hsc_host_model (
  input wire logic i_clk,
  input wire logic i_do,
  output logic o_cl,
  output logic o_ce,
  output logic o_di
);
  logic idle_hi; // Shift clock level between frames
  initial begin
    idle_hi = 1'b0;
    o_cl = 1'b0;
    o_ce = 1'b0;
    o_di = 1'b0;
  end
  // Let n falling clock edges pass
  task automatic hold(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Send n bits, lowest first, device samples on rising shift clock
  task automatic shift(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      o_cl = 1'b0;
      o_di = v[i];
      hold(4);
      o_cl = 1'b1;
      hold(4);
    end
    o_cl = idle_hi;
    o_di = ~o_di; // No stale data level after the last bit
    hold(4);
  endtask
  // Address byte with strobe low, then strobe high
  task automatic start(input logic [7:0] a);
    o_ce = 1'b0;
    shift({8'h00, a}, 8);
    o_cl = 1'b0;
    hold(4);
    o_ce = 1'b1;
    hold(4);
  endtask
  // Setting write: chip bits, zero pair, command, data
  task automatic write(input logic [3:0] c, input logic [7:0] d, input logic [1:0] chip);
    start(8'hE8);
    shift({d, c, 2'b00, chip}, 16);
    o_ce = 1'b0;
    hold(8);
  endtask
  // Readback: bit 0 stands at strobe rise, next bit after each fall
  task automatic read(input logic [7:0] a, output logic [15:0] v);
    start(a);
    hold(4);
    for (int i = 0; i < 16; i++) begin
      v[i] = i_do;
      o_cl = 1'b1;
      hold(4);
      o_cl = 1'b0;
      hold(8);
    end
    o_cl = idle_hi;
    o_ce = 1'b0;
    hold(8);
  endtask
endmodule
`default_nettype wire

// >>> hsc_pkg.sv
// Purpose: types of the serial control port
// Assumes: nothing
// Notes: constants live in hsc_consts.svh
`default_nettype none
package hsc_pkg;
  // Frame sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_ADDR = 4'h1,
    ST_WR = 4'h2,
    ST_RD = 4'h4,
    ST_IGN = 4'h8
  } hsc_state_t;
  // Event inputs from the receiver core, same clock
  typedef struct packed {
    logic input_activity_chg; // Pulse
    logic rate_result_chg;    // Pulse
    logic chan_stat_updated;  // Pulse
    logic burst_info_updated; // Pulse
    logic gpio_in_chg;        // Pulse, parallel input mode
    logic preemph_info;       // Level
  } hsc_evt_t;
  // Readback sources
  typedef struct packed {
    logic [15:0] rate;
    logic [15:0] chan;
    logic [15:0] burst;
    logic [7:0] detect;
  } hsc_rd_t;
  // Committed write command
  typedef struct packed {
    logic valid;
    logic [3:0] cmd;
    logic [7:0] data;
  } hsc_cmd_t;
endpackage
`default_nettype wire

// >>> tb_top.sv
// Purpose: self-checking bench of the serial control port
// Assumes: chip straps tied to low 0, high 1
// Notes: host pins come from hsc_host_model
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fault = 1'b0;
  logic nonpcm = 1'b0;
  logic pll_locked = 1'b0;
  logic cl, ce, di, so, so_oe_n, int_n, do_pin;
  hsc_pkg::hsc_evt_t evt = '0;
  hsc_pkg::hsc_rd_t rd = {16'hA5C3, 16'h1234, 16'h8001, 8'h5A};
  hsc_pkg::hsc_cmd_t cmd, last_cmd;
  int fail_count = 0;
  int compares = 0;
  int n_cmd = 0;
  logic [15:0] v;
  always #20 clk = ~clk;
  // Readback wire floats unless the device drives it
  assign do_pin = so_oe_n ? 1'bz : so;
  hsc_ctrl u_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_shift_timing_line(cl), .i_frame_strobe(ce),
    .i_host_serial_in(di), .i_receive_fault_flag(fault), .i_nonpcm_flag(nonpcm), .i_chip_id_low_bit(1'b0),
    .i_chip_id_high_bit(1'b1), .i_pll_locked(pll_locked), .i_evt(evt), .i_rd(rd), .o_host_serial_out(so),
    .o_host_serial_out_oe_n(so_oe_n), .o_int_n(int_n), .o_cmd(cmd));
  hsc_host_model u_host (.i_clk(clk), .i_do(do_pin), .o_cl(cl), .o_ce(ce), .o_di(di));
  // Record each committed write
  always @(posedge clk) begin
    if (cmd.valid === 1'b1) begin
      last_cmd <= cmd;
      n_cmd <= n_cmd + 1;
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Bounded wait for an interrupt level
  task automatic wait_int(input logic lvl);
    for (int i = 0; i < 40 && int_n !== lvl; i++) @(negedge clk);
    chk("int_n", {15'h0000, lvl}, {15'h0000, int_n});
    if (int_n !== lvl) wrap_up();
  endtask
  // Raise source k+1 once
  task automatic fire(input int k);
    int idx [8] = '{0, 5, 4, 3, 0, 2, 1, 0};
    @(negedge clk);
    if (k == 0) fault = ~fault;
    else if (k == 4) nonpcm = ~nonpcm;
    else if (k == 7) evt.preemph_info = ~evt.preemph_info;
    else evt[idx[k]] = 1'b1;
    @(negedge clk);
    evt[5:1] = 5'h00;
  endtask
  task automatic t_reset();
    chk("idle int_n", 16'h0001, {15'h0000, int_n});
    chk("idle oe_n", 16'h0001, {15'h0000, so_oe_n});
    $display("t_reset done");
  endtask
  task automatic t_write();
    u_host.write(4'h8, 8'hFF, 2'b10);
    u_host.write(4'h8, 8'h00, 2'b01);
    chk("write count", 16'h0001, n_cmd[15:0]);
    chk("command", 16'h18FF, {3'h0, last_cmd});
    $display("t_write done");
  endtask
  task automatic t_events();
    logic [15:0] exp;
    for (int k = 0; k < 8; k++) begin
      fire(k);
      wait_int(1'b0);
      u_host.read(8'hEB, v);
      chk("rate word", rd.rate, v);
      chk("int after other read", 16'h0000, {15'h0000, int_n});
      u_host.read(8'hEA, v);
      exp = {8'h01 << k, rd.detect};
      exp[8] = fault;
      exp[12] = nonpcm;
      chk("event status", exp, v);
      wait_int(1'b1);
    end
    $display("t_events done");
  endtask
  task automatic t_masked();
    u_host.write(4'h8, 8'h00, 2'b10);
    fire(3);
    repeat (20) @(negedge clk);
    chk("masked int_n", 16'h0001, {15'h0000, int_n});
    $display("t_masked done");
  endtask
  // Amplifier gating of sources 2 and 3, then an unknown address
  task automatic t_amp();
    logic [15:0] exp;
    u_host.write(4'h8, 8'h06, 2'b10);
    u_host.write(4'h2, 8'hC0, 2'b10);
    fire(1);
    repeat (20) @(negedge clk);
    chk("stopped amp int_n", 16'h0001, {15'h0000, int_n});
    u_host.write(4'h2, 8'h80, 2'b10);
    pll_locked = 1'b1;
    fire(2);
    repeat (20) @(negedge clk);
    chk("locked auto amp int_n", 16'h0001, {15'h0000, int_n});
    pll_locked = 1'b0;
    fire(2);
    wait_int(1'b0);
    u_host.read(8'hE9, v);
    chk("unknown address readback", 16'hZZZZ, v);
    chk("int after unknown address", 16'h0000, {15'h0000, int_n});
    u_host.read(8'hEA, v);
    exp = {8'h04, rd.detect};
    exp[8] = fault;
    exp[12] = nonpcm;
    chk("rate event status", exp, v);
    wait_int(1'b1);
    u_host.write(4'h2, 8'h00, 2'b10);
    $display("t_amp done");
  endtask
  task automatic t_reads();
    u_host.idle_hi = 1'b1;
    u_host.read(8'hEC, v);
    chk("chan word", rd.chan, v);
    u_host.read(8'hED, v);
    chk("burst word", rd.burst, v);
    chk("float after read", 16'h0001, {15'h0000, so_oe_n});
    u_host.idle_hi = 1'b0;
    $display("t_reads done");
  endtask
  task automatic t_readback_drive_allow();
    u_host.write(4'h0, 8'h02, 2'b10);
    u_host.read(8'hEC, v);
    chk("disabled readback", 16'hZZZZ, v);
    u_host.write(4'h0, 8'h00, 2'b10);
    u_host.read(8'hEC, v);
    chk("restored readback", rd.chan, v);
    $display("t_readback_drive_allow done");
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    t_reset();
    t_write();
    t_events();
    t_masked();
    t_amp();
    t_reads();
    t_readback_drive_allow();
    wrap_up();
  end
endmodule
`default_nettype wire
